// *** aim_bank_regs.svh ***
/*
  register indexes, reset values, field positions and masks of the converter configuration bank.
  assumes an AXI4-Lite slave with 32-bit data: byte address = 4 * index.
*/
`ifndef AIM_BANK_REGS_SVH
`define AIM_BANK_REGS_SVH

`define AIM_NUM_REGS        15
`define AIM_IDX_W           4
`define AIM_IDX_MUX_CTRL    4'h0
`define AIM_IDX_BIAS_EN     4'h1
`define AIM_IDX_REF_CAL     4'h2
`define AIM_IDX_GAIN_RATE   4'h3
`define AIM_IDX_OFS_LOW     4'h4
`define AIM_IDX_OFS_MID     4'h5
`define AIM_IDX_OFS_HIGH    4'h6
`define AIM_IDX_FS_LOW      4'h7
`define AIM_IDX_FS_MID      4'h8
`define AIM_IDX_FS_HIGH     4'h9
`define AIM_IDX_REV_CUR     4'ha
`define AIM_IDX_CUR_ROUTE   4'hb
`define AIM_IDX_PIO_CFG     4'hc
`define AIM_IDX_PIO_DIR     4'hd
`define AIM_IDX_PIO_VAL     4'he
`define AIM_IDX_LAST        4'he

`define AIM_RST_MUX_CTRL    8'h01
`define AIM_RST_FS_HIGH     8'h40
`define AIM_RST_ZERO        8'h00

`define AIM_BCS_MSB         7
`define AIM_BCS_LSB         6
`define AIM_PSEL_MSB        5
`define AIM_PSEL_LSB        3
`define AIM_NSEL_MSB        2
`define AIM_NSEL_LSB        0
`define AIM_CAL_MSB         2
`define AIM_CAL_LSB         0
`define AIM_CLOCK_SOURCE_FLAG_BIT     7
`define AIM_RDYMODE_BIT     3
`define AIM_REV_MSB         7
`define AIM_REV_LSB         4
`define AIM_CURRENT_MAGNITUDE_MSB        2
`define AIM_CURRENT_MAGNITUDE_LSB        0

`define AIM_WMASK_FULL      8'hff
`define AIM_WMASK_BIAS4     8'h0f
`define AIM_WMASK_TOP_RO    8'h7f
`define AIM_WMASK_LOW_NIB   8'h0f
`define AIM_CAL_NONE        3'h0

`define AIM_ADDR_IDX_MSB    5
`define AIM_ADDR_IDX_LSB    2
`define AIM_RESP_OKAY       2'h0
`define AIM_RESP_SLVERR     2'h2

`endif

// *** aim_pkg.sv ***
/*
  types shared by the configuration bank files.
  assumes nothing beyond a SystemVerilog compiler.
*/
package aim_pkg;

  typedef logic [7:0] aim_byte_t;

  // burnout source strength codes
  typedef enum logic [1:0] {
    aim_bcs_off,
    aim_bcs_low,
    aim_bcs_mid,
    aim_bcs_high
  } aim_bcs_t;

endpackage

// *** aim_regbus_if.sv ***
/*
  carrier between the AXI4-Lite slave and the register bank.
  assumes both ends sit on mclk_in; wr_en is a one-cycle pulse.
*/
`timescale 1ns/100ps
interface aim_regbus_if;
  logic              wr_en;
  logic [31:0]       wr_addr;
  aim_pkg::aim_byte_t wr_data;
  logic              wr_strb0;
  logic              wr_err;
  logic [31:0]       rd_addr;
  aim_pkg::aim_byte_t rd_data;
  logic              rd_err;

  modport slave (
    output wr_en, wr_addr, wr_data, wr_strb0, rd_addr,
    input  wr_err, rd_data, rd_err
  );
  modport bank (
    input  wr_en, wr_addr, wr_data, wr_strb0, rd_addr,
    output wr_err, rd_data, rd_err
  );
endinterface

// *** aim_axil_slave.sv ***
/*
  AXI4-Lite slave front end: holds address and data, issues one write pulse, answers.
  assumes the bank decodes combinationally in the same cycle.
*/
`timescale 1ns/100ps
`include "aim_bank_regs.svh"
module aim_axil_slave (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // axi write
  input  wire logic [31:0] awaddr_in,
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  output logic [1:0]       bresp_out,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  // axi read
  input  wire logic [31:0] araddr_in,
  input  wire logic        arvalid_in,
  output logic             arready_out,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  output logic             rvalid_out,
  input  wire logic        rready_in,
  // bank side
  aim_regbus_if.slave      bus
);
  logic        aw_held_ff, w_held_ff, ar_held_ff;
  logic [31:0] awaddr_ff, araddr_ff;
  logic [7:0]  wdata_ff;
  logic        wstrb0_ff;
  logic        aw_take, w_take, ar_take, do_wr, do_rd;
  logic        nxt_aw_held, nxt_w_held, nxt_ar_held, nxt_bvalid, nxt_rvalid;

  assign aw_take     = awvalid_in & awready_out;
  assign w_take      = wvalid_in & wready_out;
  assign ar_take     = arvalid_in & arready_out;
  // address and data may come in either order; answer waits for both
  assign do_wr       = aw_held_ff & w_held_ff & ~bvalid_out;
  assign do_rd       = ar_held_ff & ~rvalid_out;
  assign nxt_aw_held = (aw_held_ff & ~do_wr) | aw_take;
  assign nxt_w_held  = (w_held_ff & ~do_wr) | w_take;
  assign nxt_ar_held = (ar_held_ff & ~do_rd) | ar_take;
  assign nxt_bvalid  = (bvalid_out & ~bready_in) | do_wr;
  assign nxt_rvalid  = (rvalid_out & ~rready_in) | do_rd;

  assign bus.wr_en    = do_wr;
  assign bus.wr_addr  = awaddr_ff;
  assign bus.wr_data  = wdata_ff;
  assign bus.wr_strb0 = wstrb0_ff;
  assign bus.rd_addr  = araddr_ff;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_held_ff  <= 1'b0;
      w_held_ff   <= 1'b0;
      ar_held_ff  <= 1'b0;
      awaddr_ff   <= 32'h0;
      araddr_ff   <= 32'h0;
      wdata_ff    <= 8'h0;
      wstrb0_ff   <= 1'b0;
      awready_out <= 1'b0;
      wready_out  <= 1'b0;
      arready_out <= 1'b0;
      bvalid_out  <= 1'b0;
      rvalid_out  <= 1'b0;
      bresp_out   <= `AIM_RESP_OKAY;
      rresp_out   <= `AIM_RESP_OKAY;
      rdata_out   <= 32'h0;
    end else begin
      aw_held_ff  <= nxt_aw_held;
      w_held_ff   <= nxt_w_held;
      ar_held_ff  <= nxt_ar_held;
      if (aw_take) awaddr_ff <= awaddr_in;
      if (ar_take) araddr_ff <= araddr_in;
      if (w_take) wdata_ff <= wdata_in[7:0];
      if (w_take) wstrb0_ff <= wstrb_in[0];
      awready_out <= ~nxt_aw_held;
      wready_out  <= ~nxt_w_held;
      arready_out <= ~nxt_ar_held;
      bvalid_out  <= nxt_bvalid;
      rvalid_out  <= nxt_rvalid;
      if (do_wr) bresp_out <= bus.wr_err ? `AIM_RESP_SLVERR : `AIM_RESP_OKAY;
      if (do_rd) rresp_out <= bus.rd_err ? `AIM_RESP_SLVERR : `AIM_RESP_OKAY;
      if (do_rd) rdata_out <= {24'h0, bus.rd_data};
    end
  end
endmodule // aim_axil_slave

// *** aim_mux_cfg_regs.sv ***
/*
  configuration register bank of a sensor converter front end: channel multiplexer,
  burnout source, mid-supply bias, calibration and pin setup, reached over AXI4-Lite.
  assumes converter data, ready and shift status come from logic on mclk_in;
  the clock source flag comes from another domain.
*/
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "aim_bank_regs.svh"
// Contract
// (RULE1) burnout code 00 turns source off; 01, 10, 11 select three strengths.
// (RULE2) positive select bits 5:3 route input N to positive side, reset 000.
// (RULE3) negative select bits 2:0 route input N to negative side, reset 001.
// (RULE4) codes for inputs 4 to 7 only honoured on eight-input variant.
// (RULE5) multiplexer control register at index 00h, resets to 01h.
// (RULE6) calibration setting or bias enables override the chosen input pair; here only calibration blanks the routes.
// (RULE7) bias bit N high applies mid-supply bias to input N; default off.
// (RULE8) four-input variant: bias bits 7:4 read zero, software writes zeros.
// (RULE9) bias enable register at index 01h, resets to 00h.
// (RULE10) ready mode bit lets data pin also show ready; dedicated pin always does.
// (RULE11) writes to read-only or reserved bits ignored; they read fixed values. Clock source flag bit reads the live synchronised flag instead.
module aim_mux_cfg_regs #(
  parameter bit         EIGHT_INPUTS = 1'b1,
  // arbitrary revision value
  parameter logic [3:0] REVISION_ID  = 4'h5
) (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // axi write
  input  wire logic [31:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // axi read
  input  wire logic [31:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // converter status
  input  wire logic        clock_source_flag_in,
  input  wire logic        conv_data_in,
  input  wire logic        conv_ready_n_in,
  input  wire logic        conv_shift_in,
  // serial pins
  output logic             data_out_ready_pin_out,
  output logic             ready_n_pin_out,
  // analog front end control
  output logic [1:0]       burnout_current_select_out,
  output logic             burnout_source_on_out,
  output logic [7:0]       positive_route_out,
  output logic [7:0]       negative_route_out,
  output logic             channel_unsupported_out,
  output logic [7:0]       bias_enable_out,
  output logic [2:0]       calibration_mux_setting_out,
  output logic             pair_overridden_out,
  output logic [3:0]       reference_ctrl_out,
  output logic [6:0]       gain_and_rate_out,
  output logic [23:0]      offset_coef_out,
  output logic [23:0]      fullscale_coef_out,
  output logic [2:0]       current_magnitude_out,
  output logic [7:0]       current_routing_out,
  output logic [7:0]       pin_io_config_out,
  output logic [7:0]       pin_io_direction_out,
  output logic [7:0]       pin_io_value_out
);
  aim_regbus_if bus ();

  aim_axil_slave u_slave (
    .mclk_in     (mclk_in),
    .rst_n_in    (rst_n_in),
    .awaddr_in   (s_axi_awaddr_in),
    .awvalid_in  (s_axi_awvalid_in),
    .awready_out (s_axi_awready_out),
    .wdata_in    (s_axi_wdata_in),
    .wstrb_in    (s_axi_wstrb_in),
    .wvalid_in   (s_axi_wvalid_in),
    .wready_out  (s_axi_wready_out),
    .bresp_out   (s_axi_bresp_out),
    .bvalid_out  (s_axi_bvalid_out),
    .bready_in   (s_axi_bready_in),
    .araddr_in   (s_axi_araddr_in),
    .arvalid_in  (s_axi_arvalid_in),
    .arready_out (s_axi_arready_out),
    .rdata_out   (s_axi_rdata_out),
    .rresp_out   (s_axi_rresp_out),
    .rvalid_out  (s_axi_rvalid_out),
    .rready_in   (s_axi_rready_in),
    .bus         (bus)
  );

  // writable bits of each register
  function automatic aim_pkg::aim_byte_t wmask(input logic [`AIM_IDX_W-1:0] idx);
    case (idx)
      `AIM_IDX_BIAS_EN:   wmask = EIGHT_INPUTS ? `AIM_WMASK_FULL : `AIM_WMASK_BIAS4;
      `AIM_IDX_REF_CAL:   wmask = `AIM_WMASK_TOP_RO;
      `AIM_IDX_GAIN_RATE: wmask = `AIM_WMASK_TOP_RO;
      `AIM_IDX_REV_CUR:   wmask = `AIM_WMASK_LOW_NIB;
      default:            wmask = `AIM_WMASK_FULL;
    endcase
  endfunction

  function automatic aim_pkg::aim_byte_t rstval(input logic [`AIM_IDX_W-1:0] idx);
    case (idx)
      `AIM_IDX_MUX_CTRL: rstval = `AIM_RST_MUX_CTRL;
      `AIM_IDX_FS_HIGH:  rstval = `AIM_RST_FS_HIGH;
      default:           rstval = `AIM_RST_ZERO;
    endcase
  endfunction

  function automatic logic addr_ok(input logic [31:0] addr);
    addr_ok = (addr[31:`AIM_ADDR_IDX_MSB+1] == '0)
              && (addr[`AIM_ADDR_IDX_MSB:`AIM_ADDR_IDX_LSB] <= `AIM_IDX_LAST);
  endfunction

  // one-hot route of a select code, empty when not honoured
  function automatic logic [7:0] route(input logic [2:0] code, input logic blocked);
    if (blocked || (!EIGHT_INPUTS && code[2])) begin
      route = 8'h00;
    end else begin
      route = 8'h01 << code;
    end
  endfunction

  // register storage and bus decode
  aim_pkg::aim_byte_t regs_ff [`AIM_NUM_REGS];
  logic [`AIM_IDX_W-1:0] wr_idx;
  logic [`AIM_IDX_W-1:0] rd_idx;
  logic                  wr_ok;
  logic                  wr_hit;
  aim_pkg::aim_byte_t    wr_mask;
  aim_pkg::aim_byte_t    nxt_wr_value;
  aim_pkg::aim_byte_t    rd_overlay;
  aim_pkg::aim_byte_t    rd_value;

  assign wr_idx       = bus.wr_addr[`AIM_ADDR_IDX_MSB:`AIM_ADDR_IDX_LSB];
  assign rd_idx       = bus.rd_addr[`AIM_ADDR_IDX_MSB:`AIM_ADDR_IDX_LSB];
  assign wr_ok        = addr_ok(bus.wr_addr);
  // strobe lane 0 carries the whole register; other lanes are dropped
  assign wr_hit       = bus.wr_en & bus.wr_strb0 & wr_ok;
  assign wr_mask      = wmask(wr_idx);
  // read-only and reserved positions keep their stored fixed value (see RULE11)
  assign nxt_wr_value = (bus.wr_data & wr_mask) | (regs_ff[wr_idx] & ~wr_mask);
  assign bus.wr_err   = ~wr_ok;
  assign bus.rd_err   = ~addr_ok(bus.rd_addr);

  // clock source flag crosses from another domain
  logic clk_flag_meta_ff;
  logic clk_flag_ff;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_flag_meta_ff <= 1'b0;
      clk_flag_ff      <= 1'b0;
    end else begin
      clk_flag_meta_ff <= clock_source_flag_in;
      clk_flag_ff      <= clk_flag_meta_ff;
    end
  end

  // live clock flag and fixed revision merged into read-only bit positions (see RULE11)
  always_comb begin
    rd_overlay = 8'h00;
    case (rd_idx)
      `AIM_IDX_REF_CAL: rd_overlay[`AIM_CLOCK_SOURCE_FLAG_BIT] = clk_flag_ff;
      `AIM_IDX_REV_CUR: rd_overlay[`AIM_REV_MSB:`AIM_REV_LSB] = REVISION_ID;
      default:          rd_overlay = 8'h00;
    endcase
  end

  assign rd_value    = bus.rd_err ? 8'h00 : (regs_ff[rd_idx] | rd_overlay);
  assign bus.rd_data = rd_value;

  // reset values: mux control 01h, bias 00h, full-scale high 40h (see RULE5) (see RULE9)
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < `AIM_NUM_REGS; i++) begin
        regs_ff[i] <= rstval(i[`AIM_IDX_W-1:0]);
      end
    end else if (wr_hit) begin
      regs_ff[wr_idx] <= nxt_wr_value;
    end
  end

  // field views
  aim_pkg::aim_bcs_t bcs_code;
  logic [2:0]        pos_sel;
  logic [2:0]        neg_sel;
  logic [2:0]        cal_sel;
  logic              cal_active;
  logic              ready_mode;
  aim_pkg::aim_byte_t bias_bits;

  assign bcs_code   = aim_pkg::aim_bcs_t'(regs_ff[`AIM_IDX_MUX_CTRL][`AIM_BCS_MSB:`AIM_BCS_LSB]);
  assign pos_sel    = regs_ff[`AIM_IDX_MUX_CTRL][`AIM_PSEL_MSB:`AIM_PSEL_LSB];
  assign neg_sel    = regs_ff[`AIM_IDX_MUX_CTRL][`AIM_NSEL_MSB:`AIM_NSEL_LSB];
  assign cal_sel    = regs_ff[`AIM_IDX_REF_CAL][`AIM_CAL_MSB:`AIM_CAL_LSB];
  assign cal_active = (cal_sel != `AIM_CAL_NONE);
  assign ready_mode = regs_ff[`AIM_IDX_REV_CUR][`AIM_RDYMODE_BIT];
  // upper bias bits never store on the four-input variant (see RULE8)
  assign bias_bits  = regs_ff[`AIM_IDX_BIAS_EN];

  // decoded front end controls, registered
  logic [7:0] nxt_pos_route;
  logic [7:0] nxt_neg_route;
  logic       nxt_unsupported;
  logic       nxt_overridden;
  logic       nxt_burnout_on;
  logic       nxt_data_pin;

  assign nxt_pos_route   = route(pos_sel, cal_active); // see RULE2 see RULE6
  assign nxt_neg_route   = route(neg_sel, cal_active); // see RULE3 see RULE6
  // high codes on a four-input part connect nothing and raise a flag
  assign nxt_unsupported = !EIGHT_INPUTS && (pos_sel[2] || neg_sel[2]); // see RULE4
  // bias on an input takes that pin away from the plain differential pair
  assign nxt_overridden  = cal_active || (bias_bits != 8'h00); // see RULE6
  assign nxt_burnout_on  = (bcs_code != aim_pkg::aim_bcs_off); // see RULE1
  // ready shown on data pin only between shifts, so data bits stay clean
  assign nxt_data_pin    = (ready_mode && !conv_shift_in) ? conv_ready_n_in
                                                          : conv_data_in; // see RULE10

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      positive_route_out      <= 8'h00;
      negative_route_out      <= 8'h00;
      channel_unsupported_out <= 1'b0;
      pair_overridden_out     <= 1'b0;
      burnout_source_on_out   <= 1'b0;
      data_out_ready_pin_out  <= 1'b1;
      ready_n_pin_out         <= 1'b1;
    end else begin
      positive_route_out      <= nxt_pos_route;
      negative_route_out      <= nxt_neg_route;
      channel_unsupported_out <= nxt_unsupported;
      pair_overridden_out     <= nxt_overridden;
      burnout_source_on_out   <= nxt_burnout_on;
      data_out_ready_pin_out  <= nxt_data_pin;
      ready_n_pin_out         <= conv_ready_n_in; // see RULE10
    end
  end

  // plain register fields, taken straight from storage flip-flops
  assign burnout_current_select_out  = regs_ff[`AIM_IDX_MUX_CTRL][`AIM_BCS_MSB:`AIM_BCS_LSB]; // see RULE1
  assign bias_enable_out             = bias_bits; // see RULE7
  assign calibration_mux_setting_out = cal_sel;
  assign reference_ctrl_out          = regs_ff[`AIM_IDX_REF_CAL][6:3];
  assign gain_and_rate_out           = regs_ff[`AIM_IDX_GAIN_RATE][6:0];
  assign offset_coef_out             = {regs_ff[`AIM_IDX_OFS_HIGH],
                                        regs_ff[`AIM_IDX_OFS_MID],
                                        regs_ff[`AIM_IDX_OFS_LOW]};
  assign fullscale_coef_out          = {regs_ff[`AIM_IDX_FS_HIGH],
                                        regs_ff[`AIM_IDX_FS_MID],
                                        regs_ff[`AIM_IDX_FS_LOW]};
  assign current_magnitude_out       = regs_ff[`AIM_IDX_REV_CUR][`AIM_CURRENT_MAGNITUDE_MSB:`AIM_CURRENT_MAGNITUDE_LSB];
  assign current_routing_out         = regs_ff[`AIM_IDX_CUR_ROUTE];
  assign pin_io_config_out           = regs_ff[`AIM_IDX_PIO_CFG];
  assign pin_io_direction_out        = regs_ff[`AIM_IDX_PIO_DIR];
  assign pin_io_value_out            = regs_ff[`AIM_IDX_PIO_VAL];

endmodule // aim_mux_cfg_regs

// *** aim_mux_cfg_asserts.sv ***
/*
  concurrent checks on the configuration bank's front-end and pin outputs.
  assumes it is bound into aim_mux_cfg_regs and sees only its ports.
*/
`timescale 1ns/100ps
module aim_mux_cfg_asserts #(
  parameter bit EIGHT_INPUTS = 1'b1
) (
  input wire logic       mclk_in,
  input wire logic       rst_n_in,
  input wire logic       conv_data_in,
  input wire logic       conv_ready_n_in,
  input wire logic       conv_shift_in,
  input wire logic       data_out_ready_pin_out,
  input wire logic       ready_n_pin_out,
  input wire logic [1:0] burnout_current_select_out,
  input wire logic       burnout_source_on_out,
  input wire logic [7:0] positive_route_out,
  input wire logic [7:0] negative_route_out,
  input wire logic [7:0] bias_enable_out,
  input wire logic [2:0] calibration_mux_setting_out,
  input wire logic       pair_overridden_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence cal_held;
    (calibration_mux_setting_out != 3'h0) [*3];
  endsequence
  sequence bias_held;
    (|bias_enable_out) [*2];
  endsequence
  sequence sel_settled;
    $stable(burnout_current_select_out) [*2];
  endsequence

  burn_source_on_a: assert property (sel_settled |->
    burnout_source_on_out == (burnout_current_select_out != 2'h0))
    else $error("burnout enable wrong");
  route_onehot_a: assert property ($onehot0(positive_route_out)
    && $onehot0(negative_route_out)) else $error("input route not one-hot");
  narrow_route_a: assert property (!EIGHT_INPUTS |->
    positive_route_out[7:4] == 4'h0 && negative_route_out[7:4] == 4'h0)
    else $error("upper input routed");
  cal_blank_a: assert property (cal_held |->
    positive_route_out == 8'h00 && negative_route_out == 8'h00)
    else $error("routes not blanked");
  bias_flag_a: assert property (bias_held |-> pair_overridden_out)
    else $error("bias enables not flagged as override");
  override_cause_a: assert property (pair_overridden_out |-> (|bias_enable_out)
    || (|calibration_mux_setting_out) || (|$past(bias_enable_out))
    || (|$past(calibration_mux_setting_out))) else $error("override flag without cause");
  narrow_bias_a: assert property (!EIGHT_INPUTS |-> bias_enable_out[7:4] == 4'h0)
    else $error("upper bias bits set on four-input variant");
  ready_pin_a: assert property (ready_n_pin_out == $past(conv_ready_n_in))
    else $error("dedicated ready pin does not follow ready");
  data_pin_a: assert property ($past(conv_shift_in) |->
    data_out_ready_pin_out == $past(conv_data_in))
    else $error("data pin not data");
  data_src_a: assert property (data_out_ready_pin_out == $past(conv_data_in)
    || data_out_ready_pin_out == $past(conv_ready_n_in))
    else $error("data pin shows neither data nor ready");
endmodule // aim_mux_cfg_asserts

bind aim_mux_cfg_regs aim_mux_cfg_asserts #(.EIGHT_INPUTS(EIGHT_INPUTS)) u_aim_mux_cfg_asserts (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .conv_data_in(conv_data_in),
  .conv_ready_n_in(conv_ready_n_in), .conv_shift_in(conv_shift_in),
  .data_out_ready_pin_out(data_out_ready_pin_out), .ready_n_pin_out(ready_n_pin_out),
  .burnout_current_select_out(burnout_current_select_out),
  .burnout_source_on_out(burnout_source_on_out), .positive_route_out(positive_route_out),
  .negative_route_out(negative_route_out), .bias_enable_out(bias_enable_out),
  .calibration_mux_setting_out(calibration_mux_setting_out),
  .pair_overridden_out(pair_overridden_out)
);

// *** test_aim_mux_cfg_regs.sv ***
/*
  self-checking bench of the configuration bank, driven over AXI4-Lite.
  assumes the bank, its carrier files and the bound checker are compiled before it.
*/
`timescale 1ns/100ps
`include "aim_bank_regs.svh"
module test_aim_mux_cfg_regs;
  localparam logic [3:0] REV = 4'h5; // arbitrary revision value
  logic        mclk_in = 1'b0, rst_n_in = 1'b0;
  logic [31:0] s_axi_awaddr_in = '0, s_axi_wdata_in = '0, s_axi_araddr_in = '0;
  logic [3:0]  s_axi_wstrb_in = '0;
  logic        s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic        s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic        clock_source_flag_in = 1'b0, conv_data_in = 1'b1;
  logic        conv_ready_n_in = 1'b1, conv_shift_in = 1'b0;
  logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic        s_axi_rvalid_out, data_out_ready_pin_out, ready_n_pin_out;
  logic        burnout_source_on_out, pair_overridden_out, channel_unsupported_out;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, burnout_current_select_out;
  logic [31:0] s_axi_rdata_out;
  logic [7:0]  positive_route_out, negative_route_out, bias_enable_out;
  logic [2:0]  calibration_mux_setting_out, current_magnitude_out;
  logic [6:0]  gain_and_rate_out;
  int          err_count = 0, samples_checked = 0, cycles = 0;

  aim_mux_cfg_regs #(.EIGHT_INPUTS(1'b1), .REVISION_ID(REV)) u_aim_mux_cfg_regs (
    .*, .reference_ctrl_out(), .offset_coef_out(), .fullscale_coef_out(),
    .current_routing_out(), .pin_io_config_out(), .pin_io_direction_out(),
    .pin_io_value_out()
  );

  always #4 mclk_in = ~mclk_in;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // tests take a few hundred cycles
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [31:0] ba(input logic [3:0] i);
    return {26'h0, i, 2'h0};
  endfunction

  function automatic logic [31:0] rst_val(input int i);
    case (i)
      0: return 32'h01;
      9: return 32'h40;
      10: return {24'h0, REV, 4'h0};
      default: return 32'h00;
    endcase
  endfunction

  task automatic wr(input logic [31:0] a, input logic [7:0] v, input logic [3:0] s,
                    output logic [1:0] resp);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge mclk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {24'h0, v};
    s_axi_wstrb_in <= s;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge mclk_in);
      if (s_axi_awvalid_in && s_axi_awready_out === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid_in <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid_in <= 1'b0;
      end
    end
    s_axi_bready_in <= 1'b1;
    do @(posedge mclk_in); while (s_axi_bvalid_out !== 1'b1);
    resp = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge mclk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    do @(posedge mclk_in); while (s_axi_arready_out !== 1'b1);
    s_axi_arvalid_in <= 1'b0;
    s_axi_rready_in <= 1'b1;
    do @(posedge mclk_in); while (s_axi_rvalid_out !== 1'b1);
    d = s_axi_rdata_out;
    resp = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask

  task automatic wr_chk(input logic [3:0] i, input logic [7:0] v);
    logic [1:0] r;
    wr(ba(i), v, 4'h1, r);
    chk("write resp", `AIM_RESP_OKAY, {30'h0, r});
  endtask

  task automatic rd_chk(input logic [3:0] i, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(ba(i), d, r);
    chk("read resp", `AIM_RESP_OKAY, {30'h0, r});
    chk($sformatf("reg %h", i), exp, d);
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    for (int i = 0; i < 15; i++) rd_chk(4'(i), rst_val(i));
    chk("pos route", 32'h01, {24'h0, positive_route_out});
    chk("neg route", 32'h02, {24'h0, negative_route_out});
    // every burnout code and every channel code on both sides
    for (int k = 0; k < 8; k++) begin
      d = {24'h0, 2'(k), 3'(k), 3'(7 - k)};
      wr_chk(`AIM_IDX_MUX_CTRL, d[7:0]);
      rd_chk(`AIM_IDX_MUX_CTRL, d);
      chk("burnout code", 32'(k % 4), {30'h0, burnout_current_select_out});
      chk("burnout on", 32'(k % 4 != 0), {31'h0, burnout_source_on_out});
      chk("pos route", 32'h1 << k, {24'h0, positive_route_out});
      chk("neg route", 32'h1 << (7 - k), {24'h0, negative_route_out});
      chk("unsupported", 32'h0, {31'h0, channel_unsupported_out});
    end
    wr_chk(`AIM_IDX_BIAS_EN, 8'ha5);
    rd_chk(`AIM_IDX_BIAS_EN, 32'ha5);
    chk("bias out", 32'ha5, {24'h0, bias_enable_out});
    chk("overridden", 32'h1, {31'h0, pair_overridden_out});
    wr_chk(`AIM_IDX_BIAS_EN, 8'h00);
    repeat (2) @(posedge mclk_in);
    chk("overridden", 32'h0, {31'h0, pair_overridden_out});
    // clock flag bit is read-only: write of 1 lost while flag is 0
    wr_chk(`AIM_IDX_REF_CAL, 8'h83);
    rd_chk(`AIM_IDX_REF_CAL, 32'h03);
    chk("cal setting", 32'h3, {29'h0, calibration_mux_setting_out});
    chk("pos blank", 32'h0, {24'h0, positive_route_out});
    chk("neg blank", 32'h0, {24'h0, negative_route_out});
    chk("overridden", 32'h1, {31'h0, pair_overridden_out});
    clock_source_flag_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    rd_chk(`AIM_IDX_REF_CAL, 32'h83);
    wr_chk(`AIM_IDX_REF_CAL, 8'h00);
    wr_chk(`AIM_IDX_GAIN_RATE, 8'hff);
    rd_chk(`AIM_IDX_GAIN_RATE, 32'h7f);
    chk("gain out", 32'h7f, {25'h0, gain_and_rate_out});
    wr_chk(`AIM_IDX_REV_CUR, 8'hff);
    rd_chk(`AIM_IDX_REV_CUR, {24'h0, REV, 4'hf});
    chk("magnitude", 32'h7, {29'h0, current_magnitude_out});
    // ready mode on: data pin shows ready while not shifting
    conv_ready_n_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    chk("data pin", 32'h0, {31'h0, data_out_ready_pin_out});
    chk("ready pin", 32'h0, {31'h0, ready_n_pin_out});
    conv_shift_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    chk("data pin", 32'h1, {31'h0, data_out_ready_pin_out});
    conv_shift_in <= 1'b0;
    wr_chk(`AIM_IDX_REV_CUR, 8'h00);
    repeat (3) @(posedge mclk_in);
    chk("data pin", 32'h1, {31'h0, data_out_ready_pin_out});
    chk("ready pin", 32'h0, {31'h0, ready_n_pin_out});
    conv_ready_n_in <= 1'b1;
    // unmapped index and a write with its byte lane off
    wr(ba(4'hf), 8'h11, 4'h1, r);
    chk("bad write resp", `AIM_RESP_SLVERR, {30'h0, r});
    rd(ba(4'hf), d, r);
    chk("bad read resp", `AIM_RESP_SLVERR, {30'h0, r});
    chk("bad read data", 32'h0, d);
    wr(ba(`AIM_IDX_PIO_VAL), 8'h5a, 4'h0, r);
    chk("no lane resp", `AIM_RESP_OKAY, {30'h0, r});
    rd_chk(`AIM_IDX_PIO_VAL, 32'h00);
    give_verdict();
  end
endmodule // test_aim_mux_cfg_regs
